// >>> design/tpcg_pkg.sv
// Shared constants for the two-phase clock generator.
// Assumes a single system clock that stands in for the master clock.
package tpcg_pkg;
   // Divide ratios
   localparam int unsigned TPCG_DIV7 = 7;
   localparam int unsigned TPCG_DIV8 = 8;
   // Ring lengths
   localparam int unsigned TPCG_RING7 = 7;
   localparam int unsigned TPCG_RING4 = 4;
   // Reset value of the ring: one token in stage zero
   localparam logic [6:0] TPCG_RING_INIT = 7'h01;
   // Stages 0..6 in seven mode: phase one on stages 0,1; phase two on 4,5
   localparam logic [6:0] TPCG_P1_MASK7 = 7'h03;
   localparam logic [6:0] TPCG_P2_MASK7 = 7'h30;
   // Four mode: phase one on stage 0, phase two on stage 2
   localparam logic [3:0] TPCG_P1_MASK4 = 4'h1;
   localparam logic [3:0] TPCG_P2_MASK4 = 4'h4;
   // Delay from acknowledge to halt request, microseconds
   localparam int unsigned TPCG_ACK_STOP_US = 1;
   localparam int unsigned TPCG_CLK_MHZ = 100;
   // Debounce filter length in clocks
   localparam int unsigned TPCG_DEB_CYCLES = 4;
   // Single-step states
   typedef enum logic [1:0] {
      TPCG_ST_HALT = 2'b00,
      TPCG_ST_RUN = 2'b01,
      TPCG_ST_WAIT = 2'b10
   } tpcg_step_t;
endpackage

// >>> design/tpcg_ring.sv
// Programmable circulating token ring and phase decoder.
// Assumes mode is already synchronised to clk_i.
`timescale 1ns/1ns
`default_nettype none
module tpcg_ring
   import tpcg_pkg::*;
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic div7_i,
   output logic phase_one_o,
   output logic phase_two_o
);
   logic [6:0] ring_q;
   logic [6:0] ring_d;
   logic half_q;
   logic half_d;
   logic p1_q;
   logic p1_d;
   logic p2_q;
   logic p2_d;
   logic div7_q;
   logic div7_d;
   logic [3:0] r4;

   // Returns one when exactly one bit of v is set
   function automatic logic one_hot7(input logic [6:0] v);
      logic [3:0] n;
      n = 4'h0;
      for (int i = 0; i < 7; i++) begin
         n = n + {3'h0, v[i]};
      end
      return (n == 4'h1);
   endfunction

   assign r4 = ring_q[3:0];

   // Ring step, halving, phase decode
   always_comb begin
      div7_d = div7_i;
      half_d = ~half_q;
      ring_d = ring_q;
      if (div7_q != div7_i) begin
         ring_d = TPCG_RING_INIT;
         half_d = 1'b0;
      end else if (div7_q) begin
         if (!one_hot7(ring_q)) begin
            ring_d = TPCG_RING_INIT;
         end else begin
            ring_d = {ring_q[5:0], ring_q[6]};
         end
      end else if (!one_hot7({3'h0, r4})) begin
         ring_d = TPCG_RING_INIT;
      end else if (half_q) begin
         ring_d = {3'h0, r4[2:0], r4[3]};
      end
      if (div7_q) begin
         p1_d = |(ring_d & TPCG_P1_MASK7);
         p2_d = |(ring_d & TPCG_P2_MASK7);
      end else begin
         p1_d = |(ring_d[3:0] & TPCG_P1_MASK4);
         p2_d = |(ring_d[3:0] & TPCG_P2_MASK4);
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ring_q <= TPCG_RING_INIT;
         half_q <= 1'b0;
         p1_q <= 1'b0;
         p2_q <= 1'b0;
         div7_q <= 1'b0;
      end else begin
         ring_q <= ring_d;
         half_q <= half_d;
         p1_q <= p1_d;
         p2_q <= p2_d;
         div7_q <= div7_d;
      end
   end

   assign phase_one_o = p1_q;
   assign phase_two_o = p2_q;
endmodule
`default_nettype wire

// >>> design/tpcg_sync.sv
// Two flip-flop synchroniser for one pin level.
// Assumes the pin is asynchronous to clk_i.
`timescale 1ns/1ns
`default_nettype none
module tpcg_sync (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic async_i,
   output logic sync_o
);
   logic meta_q;
   logic meta_d;
   logic sync_q;
   logic sync_d;
   // Next values
   always_comb begin
      meta_d = async_i;
      sync_d = meta_q;
   end
   // Two stages
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end
   assign sync_o = sync_q;
endmodule
`default_nettype wire

// >>> design/tpcg_top.sv
// Two-phase clock generator with power-on reset and single-step control.
// Assumes clk_i stands in for the crystal master clock; all pins are
// asynchronous and are synchronised here.
//
// What this block does
// - Mode high divides master clock by seven, mode low by eight.
// - Seven mode circulates one token through seven stages each clock.
// - Eight mode halves the clock, then steps a four-stage ring.
// - Eight mode gives equal quarter widths and gaps.
// - Mode-dependent decode gates make the non-overlapping phases.
// - TTL-level positive-true copies of both phases beside MOS outputs.
// - Crystal across both pins or external source on the first pin.
// - Active-low reset output drives all family reset inputs.
// - Reset held until the RC sense input crosses the threshold.
// - One halt-request release per step lets one instruction run.
// - Changeover pushbutton is debounced internally.
// - Halt-request output drives the processor stop input.
// - Seven mode: pulses two sevenths, gaps two and one seventh.
`timescale 1ns/1ns
`default_nettype none
module tpcg_top
   import tpcg_pkg::*;
#(
   parameter int unsigned DEB_CYCLES = TPCG_DEB_CYCLES
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic crystal_in_i,
   output logic crystal_out_o,
   input wire logic mode_div7_i,
   input wire logic reset_sense_i,
   output logic reset_n_o,
   input wire logic contact_open_i,
   input wire logic contact_closed_i,
   input wire logic stop_ack_i,
   output logic halt_req_o,
   output logic phase_one_o,
   output logic phase_two_o,
   output logic phase_one_ttl_out_o,
   output logic phase_two_ttl_out_o
);
   // Acknowledge-to-stop budget in clocks
   localparam int unsigned ACK_CYC = TPCG_ACK_STOP_US * TPCG_CLK_MHZ;
   localparam int unsigned DW = $clog2(DEB_CYCLES + 1);
   // Clocks from acknowledge low at the pin to stop high at the pin:
   // two synchroniser stages and the state register
   localparam int unsigned ACK_LAT = 3;

   // ---------------------------------------------------------------
   // Elaboration checks
   // ---------------------------------------------------------------
   // The debounce counter needs at least one count and a sane width
   if (DEB_CYCLES < 1 || DEB_CYCLES > 4096) begin : g_deb_chk
      $error("DEB_CYCLES out of range");
   end
   // A stop request later than the acknowledge budget would let the
   // processor start a second instruction on a single step
   if (ACK_LAT > ACK_CYC) begin : g_ack_chk
      $error("Stop request slower than the acknowledge budget");
   end

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   // Every pin is asynchronous to clk_i, so each passes two flip-flops
   // before any logic reads it. All of them read low during reset:
   // divide by eight, sense low, no contact made, acknowledge low.
   // Logic below must not mistake that for a real event.
   logic mode_s;
   logic sense_s;
   logic open_s;
   logic closed_s;
   logic ack_s;
   logic xin_s;

   // Mode pin, a static strap in practice
   tpcg_sync u_sync_mode (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .async_i(mode_div7_i),
      .sync_o(mode_s)
   );
   // RC level detector input
   tpcg_sync u_sync_sense (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .async_i(reset_sense_i),
      .sync_o(sense_s)
   );
   // Normally-open contact of the step switch
   tpcg_sync u_sync_open (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .async_i(contact_open_i),
      .sync_o(open_s)
   );
   // Normally-closed contact of the step switch
   tpcg_sync u_sync_closed (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .async_i(contact_closed_i),
      .sync_o(closed_s)
   );
   // Processor stop acknowledge
   tpcg_sync u_sync_ack (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .async_i(stop_ack_i),
      .sync_o(ack_s)
   );
   // Oscillator input pin
   tpcg_sync u_sync_xin (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .async_i(crystal_in_i),
      .sync_o(xin_s)
   );

   // ---------------------------------------------------------------
   // Oscillator and phase generation
   // ---------------------------------------------------------------
   logic p1;
   logic p2;
   logic xo_q;
   logic xo_d;

   // Inverting stage back to the crystal; unused for an external source.
   // It works on the synchronised pin, so crystal_out_o trails the pin
   // by three clocks; a real oscillator closes this loop in analog.
   assign xo_d = ~xin_s;

   // The ring steps on every clock in seven mode and on every second
   // clock in eight mode; a change of mode restarts it from the token
   // stage, so the first cycle after a change may be short.
   tpcg_ring u_ring (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .div7_i(mode_s),
      .phase_one_o(p1),
      .phase_two_o(p2)
   );

   logic p1t_q;
   logic p1t_d;
   logic p2t_q;
   logic p2t_d;

   // TTL copies follow the MOS phases, positive true.
   // They are registered once more, so they lag the MOS phases by one
   // clock and can never lead them.
   always_comb begin
      p1t_d = p1;
      p2t_d = p2;
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         p1t_q <= 1'b0;
         p2t_q <= 1'b0;
         xo_q <= 1'b0;
      end else begin
         p1t_q <= p1t_d;
         p2t_q <= p2t_d;
         xo_q <= xo_d;
      end
   end

   assign phase_one_o = p1;
   assign phase_two_o = p2;
   assign phase_one_ttl_out_o = p1t_q;
   assign phase_two_ttl_out_o = p2t_q;
   assign crystal_out_o = xo_q;

   // ---------------------------------------------------------------
   // Power-on reset level detector
   // ---------------------------------------------------------------
   logic rst_n_q;
   logic rst_n_d;

   // Reset stays low while the sensed RC level is below threshold.
   // The output trails the pin by three clocks and re-asserts whenever
   // the level drops again, so a brown-out also resets the family.
   always_comb begin
      rst_n_d = sense_s;
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rst_n_q <= 1'b0;
      end else begin
         rst_n_q <= rst_n_d;
      end
   end

   assign reset_n_o = rst_n_q;

   // ---------------------------------------------------------------
   // Contact debounce latch
   // ---------------------------------------------------------------
   logic latch_q;
   logic latch_d;
   logic [DW-1:0] deb_q;
   logic [DW-1:0] deb_d;
   logic step_req;

   // Set by open contact, cleared by closed, held while both open.
   // The open contact must read alone for DEB_CYCLES+1 clocks before the
   // latch sets; any bounce back to both or neither restarts the count.
   // The closed contact clears at once, which is safe because a clear
   // never starts a step.
   always_comb begin
      latch_d = latch_q;
      deb_d = deb_q;
      if (open_s && !closed_s) begin
         if (deb_q == DW'(DEB_CYCLES)) begin
            latch_d = 1'b1;
         end else begin
            deb_d = deb_q + DW'(1);
         end
      end else if (closed_s && !open_s) begin
         latch_d = 1'b0;
         deb_d = '0;
      end else begin
         deb_d = '0;
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         latch_q <= 1'b0;
         deb_q <= '0;
      end else begin
         latch_q <= latch_d;
         deb_q <= deb_d;
      end
   end

   // One request per rising latch, taken from the next value
   assign step_req = latch_d && !latch_q;

   // ---------------------------------------------------------------
   // Single-step sequencer
   // ---------------------------------------------------------------
   tpcg_step_t st_q;
   tpcg_step_t st_d;
   logic halt_q;
   logic halt_d;
   logic pend_q;
   logic pend_d;

   // Drop halt request until acknowledge falls, then raise it on ack.
   // Walk of one step:
   //   HALT with a pending step and acknowledge high: halt request drops.
   //   RUN: the processor leaves its stop state and lowers acknowledge;
   //   three clocks later the halt request is high again, well inside
   //   the processor's first instruction, so it stops after that one.
   //   WAIT: acknowledge returns high and the sequencer is ready again.
   // A step asked for while one runs is kept in pend_q and served next.
   always_comb begin
      st_d = st_q;
      halt_d = halt_q;
      pend_d = pend_q | step_req;
      case (st_q)
         TPCG_ST_HALT: begin
            if (pend_q && ack_s) begin
               halt_d = 1'b0;
               pend_d = step_req;
               st_d = TPCG_ST_RUN;
            end
         end
         TPCG_ST_RUN: begin
            if (!ack_s) begin
               halt_d = 1'b1;
               st_d = TPCG_ST_WAIT;
            end
         end
         TPCG_ST_WAIT: begin
            if (ack_s) begin
               st_d = TPCG_ST_HALT;
            end
         end
         default: begin
            st_d = TPCG_ST_HALT;
         end
      endcase
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st_q <= TPCG_ST_HALT;
         halt_q <= 1'b1;
         pend_q <= 1'b0;
      end else begin
         st_q <= st_d;
         halt_q <= halt_d;
         pend_q <= pend_d;
      end
   end

   assign halt_req_o = halt_q;
endmodule
`default_nettype wire

// >>> sim/tpcg_cpu_model.sv
// Behavioural processor side: stop input and stop acknowledge.
// Assumes halt_req_i comes straight from the generator.
`timescale 1ns/1ns
`default_nettype none
module tpcg_cpu_model #(
   parameter int RUN_DLY = 1,
   parameter int INS_LEN = 6
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic halt_req_i,
   output logic stop_ack_o,
   output int instr_cnt_o
);
   int cnt;
   // Stops at an instruction end while halt is asked, then acknowledges
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         stop_ack_o <= 1'b1;
         cnt <= 0;
         instr_cnt_o <= 0;
      end else if (stop_ack_o) begin
         cnt <= halt_req_i ? 0 : cnt + 1;
         if (!halt_req_i && cnt == RUN_DLY) begin
            stop_ack_o <= 1'b0;
            cnt <= 0;
         end
      end else begin
         cnt <= cnt + 1;
         if (cnt == INS_LEN) begin
            instr_cnt_o <= instr_cnt_o + 1;
            cnt <= 0;
            stop_ack_o <= halt_req_i;
         end
      end
   end
endmodule
`default_nettype wire

// >>> sim/tpcg_props.sv
// Port checker for the two-phase clock generator.
// Assumes it is bound to tpcg_top and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module tpcg_props (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic crystal_in_i,
   input wire logic crystal_out_o,
   input wire logic mode_div7_i,
   input wire logic reset_sense_i,
   input wire logic reset_n_o,
   input wire logic stop_ack_i,
   input wire logic halt_req_o,
   input wire logic phase_one_o,
   input wire logic phase_two_o,
   input wire logic phase_one_ttl_out_o,
   input wire logic phase_two_ttl_out_o
);
   logic [4:0] up_q, up_d, mst_q, mst_d;
   logic mode_q, mode_d;
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   // Cycles since reset release and since the last mode change
   always_comb begin
      up_d = (up_q == 5'h1F) ? up_q : up_q + 5'h01;
      mst_d = (mst_q == 5'h1F) ? mst_q : mst_q + 5'h01;
      if (mode_q != mode_div7_i) begin
         mst_d = 5'h00;
      end
      mode_d = mode_div7_i;
   end
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         up_q <= 5'h00;
         mst_q <= 5'h00;
         mode_q <= 1'b0;
      end else begin
         up_q <= up_d;
         mst_q <= mst_d;
         mode_q <= mode_d;
      end
   end
   // Gap and phase-two stretches of one phase cycle
   sequence s_gap2;
      (!phase_one_o && !phase_two_o)[*2];
   endsequence
   sequence s_ph2;
      (phase_two_o && !phase_one_o)[*2];
   endsequence
   a_div8_shape: assert property (disable iff (sys_rst_i || mst_q < 5'h10)
      $rose(phase_one_o) && !mode_div7_i |=> phase_one_o ##1 s_gap2
      ##1 s_ph2 ##1 s_gap2 ##1 phase_one_o)
      else $error("divide by eight phase shape wrong");
   a_div7_shape: assert property (disable iff (sys_rst_i || mst_q < 5'h10)
      $rose(phase_one_o) && mode_div7_i |=> phase_one_o ##1 s_gap2
      ##1 s_ph2 ##1 (!phase_one_o && !phase_two_o) ##1 phase_one_o)
      else $error("divide by seven phase shape wrong");
   a_no_overlap: assert property (!(phase_one_o && phase_two_o))
      else $error("phases overlap");
   a_ttl_one: assert property (up_q >= 5'h02 |->
      phase_one_ttl_out_o == $past(phase_one_o))
      else $error("phase one copy wrong");
   a_ttl_two: assert property (up_q >= 5'h02 |->
      phase_two_ttl_out_o == $past(phase_two_o))
      else $error("phase two copy wrong");
   a_reset_track: assert property (up_q >= 5'h04 |->
      reset_n_o == $past(reset_sense_i, 3))
      else $error("reset output does not follow sense");
   a_osc_invert: assert property (up_q >= 5'h04 |->
      crystal_out_o == !$past(crystal_in_i, 3))
      else $error("oscillator output wrong");
   a_step_start: assert property ($fell(halt_req_o) |->
      $past(stop_ack_i, 3) ##1 !halt_req_o[*2])
      else $error("step released without acknowledge");
   a_step_end: assert property ($rose(halt_req_o) |->
      !$past(stop_ack_i, 3))
      else $error("halt raised before processor ran");
   a_ack_stop: assert property ($fell(stop_ack_i) && !halt_req_o |->
      ##[1:3] halt_req_o)
      else $error("stop request late after acknowledge");
endmodule
bind tpcg_top tpcg_props tpcg_props_inst (.clk_i(clk_i),
   .sys_rst_i(sys_rst_i), .crystal_in_i(crystal_in_i),
   .crystal_out_o(crystal_out_o), .mode_div7_i(mode_div7_i),
   .reset_sense_i(reset_sense_i), .reset_n_o(reset_n_o),
   .stop_ack_i(stop_ack_i), .halt_req_o(halt_req_o),
   .phase_one_o(phase_one_o), .phase_two_o(phase_two_o),
   .phase_one_ttl_out_o(phase_one_ttl_out_o),
   .phase_two_ttl_out_o(phase_two_ttl_out_o));
`default_nettype wire

// >>> sim/tpcg_top_test.sv
// Self-checking bench for the two-phase clock generator.
// Assumes the processor model answers on the stop lines.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
   mismatches++; $display("[FAIL] %s exp %0h got %0h", nm, ex, got); end end
module tpcg_top_test;
   logic clk_i = 0, sys_rst_i = 1, crystal_in_i = 0, mode_div7_i = 0;
   logic reset_sense_i = 0, contact_open_i = 0, contact_closed_i = 1;
   logic crystal_out_o, reset_n_o, halt_req_o, ack, p1, p2, t1, t2;
   logic e1, e2, l1, l2;
   logic hs[$], hx[$];
   int instrs, exp_ins, mismatches, n_checks, i, k;
   logic [31:0] seed = 32'h4EBD;
   // ----
   // Clock, design and processor model
   // ----
   always #5 clk_i = ~clk_i;
   tpcg_top #(.DEB_CYCLES(4)) tpcg_top_inst (.clk_i(clk_i),
      .sys_rst_i(sys_rst_i), .crystal_in_i(crystal_in_i),
      .crystal_out_o(crystal_out_o), .mode_div7_i(mode_div7_i),
      .reset_sense_i(reset_sense_i), .reset_n_o(reset_n_o),
      .contact_open_i(contact_open_i), .contact_closed_i(contact_closed_i),
      .stop_ack_i(ack), .halt_req_o(halt_req_o), .phase_one_o(p1),
      .phase_two_o(p2), .phase_one_ttl_out_o(t1), .phase_two_ttl_out_o(t2));
   tpcg_cpu_model tpcg_cpu_model_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .halt_req_i(halt_req_o), .stop_ack_o(ack), .instr_cnt_o(instrs));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return (s >> 1) ^ (s[0] ? 32'h80200003 : 32'h0);
   endfunction
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Two phase cycles against the expected stage pattern
   task automatic phases(input int per);
      l1 = 1'b1;
      for (k = 0; k < 40 && !(p1 === 1'b1 && l1 === 1'b0); k++) begin
         l1 = p1;
         @(negedge clk_i);
      end
      `CHK("ph1_found", 1'b1, k < 40)
      for (k = 0; k < 2 * per; k++) begin
         e1 = (k % per) < 2;
         e2 = (k % per) inside {4, 5};
         `CHK("ph1", e1, p1)
         `CHK("ph2", e2, p2)
         if (k > 0) begin
            `CHK("ttl1", l1, t1)
            `CHK("ttl2", l2, t2)
         end
         l1 = e1;
         l2 = e2;
         @(negedge clk_i);
      end
      $display("phase test %0d done", per);
   endtask
   // Switch press held for a number of cycles, then released
   task automatic press(input int hold, input logic both);
      @(negedge clk_i);
      contact_open_i = 1'b1;
      contact_closed_i = both;
      repeat (hold) @(negedge clk_i);
      contact_open_i = 1'b0;
      contact_closed_i = 1'b1;
      repeat (8) @(negedge clk_i);
   endtask
   task automatic settle();
      for (k = 0; k < 300 && !(instrs == exp_ins && ack === 1'b1); k++)
         @(negedge clk_i);
      `CHK("settled", 1'b1, k < 300)
      repeat (30) @(negedge clk_i);
      `CHK("instr", exp_ins, instrs)
      `CHK("halt", 1'b1, halt_req_o)
   endtask
   initial begin
      #(20000 * 10);
      mismatches++;
      wrap_up();
   end
   initial begin
      repeat (3) @(posedge clk_i);
      @(negedge clk_i);
      sys_rst_i = 1'b0;
      `CHK("halt", 1'b1, halt_req_o)
      `CHK("rst_n", 1'b0, reset_n_o)
      for (i = 0; i < 200; i++) begin
         @(negedge clk_i);
         if (i >= 3) begin
            `CHK("rst_n", hs[2], reset_n_o)
            `CHK("xout", ~hx[2], crystal_out_o)
         end
         seed = lfsr(seed);
         reset_sense_i = seed[3];
         crystal_in_i = seed[7];
         hs.push_front(reset_sense_i);
         hx.push_front(crystal_in_i);
      end
      reset_sense_i = 1'b1;
      $display("reset and oscillator test done");
      phases(8);
      mode_div7_i = 1'b1;
      repeat (20) @(negedge clk_i);
      phases(7);
      exp_ins = 0;
      press(2, 1'b0);
      press(12, 1'b1);
      settle();
      exp_ins = 3;
      press(12, 1'b0);
      press(12, 1'b0);
      press(12, 1'b0);
      settle();
      $display("single step test done");
      sys_rst_i = 1'b1;
      @(negedge clk_i);
      `CHK("halt", 1'b1, halt_req_o)
      `CHK("rst_n", 1'b0, reset_n_o)
      sys_rst_i = 1'b0;
      repeat (20) @(negedge clk_i);
      phases(7);
      wrap_up();
   end
endmodule
`default_nettype wire
